/* core/qlt_params.svh */
`ifndef QLT_PARAMS_SVH
`define QLT_PARAMS_SVH

// ============================================================
// Channel count and register geometry
`define QLT_NCH             4
`define QLT_REG_W           8
`define QLT_IDX_LSB         2
`define QLT_IDX_MSB         9

// ============================================================
// Register indices (byte address is four times the index)
`define QLT_IDX_CH0_CTRL    8'h00
`define QLT_IDX_CH1_CTRL    8'h01
`define QLT_IDX_CH2_CTRL    8'h02
`define QLT_IDX_CH3_CTRL    8'h03
`define QLT_IDX_STATUS      8'h40
`define QLT_IDX_GLOBAL      8'h42

// ============================================================
// Channel control fields
`define QLT_CH_TX_ON_BIT    0
`define QLT_CH_ALL_ONES_BIT 1
`define QLT_CH_RX_PWR_BIT   2
`define QLT_CH_CTRL_RST     8'h04

// ============================================================
// Global transmit control fields
`define QLT_GL_PIN_SEL_BIT  6
`define QLT_GL_CTRL_RST     8'h00

// ============================================================
// Status fields
`define QLT_ST_MODE_BIT     0
`define QLT_ST_TXEN_LSB     4
`define QLT_ST_AOS_LSB      8
`define QLT_ST_TURN_ON_LSB  12

// ============================================================
// Bus constants
`define QLT_HTRANS_ACT_BIT  1
`define QLT_HRESP_OKAY      1'h0
`define QLT_RDATA_ZERO      32'h0000_0000

`endif

/* core/qlt_pkg.sv */
package qlt_pkg;

  // ============================================================
  // Bus data-phase states
  typedef enum logic [3:0] {
    QLT_DP_IDLE  = 4'b0001,
    QLT_DP_WRITE = 4'b0010,
    QLT_DP_RWAIT = 4'b0100,
    QLT_DP_RDONE = 4'b1000
  } qlt_dp_e;

  // ============================================================
  // Host-clock state of the top level
  typedef struct packed {
    logic            mode_meta;
    logic            mode_hw;
    logic [3:0]      aos_meta;
    logic [3:0]      aos_pin;
    logic [3:0]      on_meta;
    logic [3:0]      on_pin;
    logic [3:0]      txen_meta;
    logic [3:0]      txen;
    logic [3:0][7:0] ch_ctrl;
    logic [7:0]      gl_ctrl;
    qlt_dp_e         dp;
    logic [7:0]      dp_idx;
    logic [31:0]     rdata;
    logic [3:0]      aos_ctl;
    logic [3:0]      on_ctl;
    logic [3:0]      rx_pwr;
  } qlt_top_s;

  // ============================================================
  // Line-clock state of one channel
  typedef struct packed {
    logic aos_meta;
    logic aos;
    logic on_meta;
    logic on;
    logic pos;
    logic neg;
    logic ones_phase;
    logic drv_a;
    logic drv_b;
    logic drv_oe;
  } qlt_ch_s;

endpackage : qlt_pkg

/* core/qlt_tx_channel.sv */
`timescale 1ns/1ps
`include "qlt_params.svh"

module qlt_tx_channel (
  // Line clock and reset
  input  wire logic tx_line_clock,
  input  wire logic hresetn,
  // Controls from the host-clock domain (levels)
  input  wire logic aos_ctl,
  input  wire logic on_ctl,
  // Data from the framer
  input  wire logic tx_positive_rail_in,
  input  wire logic tx_negative_rail_in,
  // Line driver
  output logic      line_driver_out_a,
  output logic      line_driver_out_b,
  output logic      line_driver_oe
);

  // ============================================================
  // Reset release synchronised to the line clock
  logic [1:0]       rst_sync_q;

  always_ff @(posedge tx_line_clock or negedge hresetn) begin
    if (!hresetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end

  // ============================================================
  // Channel state
  qlt_pkg::qlt_ch_s q, d;

  always_comb begin
    d = q;
    // Controls arrive as levels and settle through two flops
    d.aos_meta = aos_ctl;
    d.aos      = q.aos_meta;
    d.on_meta  = on_ctl;
    d.on       = q.on_meta;
    // Both rails latched on the same line clock edge
    d.pos      = tx_positive_rail_in;
    d.neg      = tx_negative_rail_in;
    // All outbound timing comes from this clock only
    if (!q.on) begin
      d.drv_oe     = 1'h0;
      d.drv_a      = 1'h0;
      d.drv_b      = 1'h0;
      d.ones_phase = 1'h0;
    end else if (q.aos) begin
      // Unframed marks with alternating polarity
      d.drv_oe     = 1'h1;
      d.ones_phase = ~q.ones_phase;
      d.drv_a      = ~q.ones_phase;
      d.drv_b      = q.ones_phase;
    end else begin
      d.drv_oe     = 1'h1;
      d.ones_phase = 1'h0;
      d.drv_a      = q.pos;
      d.drv_b      = q.neg;
    end
  end

  always_ff @(posedge tx_line_clock or negedge rst_sync_q[1]) begin
    if (!rst_sync_q[1]) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign line_driver_out_a = q.drv_a;
  assign line_driver_out_b = q.drv_b;
  assign line_driver_oe    = q.drv_oe;

endmodule : qlt_tx_channel

/* core/qlt_top.sv */
// Summary of operation
// - Latch both rails on channel line clock
// - Line clock times all outbound signalling
// - Hardware mode: all-ones pin high sends ones
// - Hardware mode: all-ones pin low sends traffic
// - Host mode: all-ones pins lose their meaning
// - Turn-on pin enables transmitter only
// - Turn-on zero floats both driver outputs
// - Hardware mode: receivers always powered
// - Receiver power control only in host mode
// - Host mode: register bit switches transmitter
// - Global bit six hands turn-on control to pins
// - Undriven all-ones pin counts as low
// - Negative rail sampled with positive rail
// - Mode pin low host, high hardware
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`include "qlt_params.svh"

module qlt_top (
  // Clock and reset
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // AHB-Lite slave
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic [31:0]                  hrdata,
  output logic                         hresp,
  // Mode and per-channel control pins
  input  wire logic                    control_mode_select,
  input  wire logic [`QLT_NCH-1:0]     tx_all_ones_command,
  input  wire logic [`QLT_NCH-1:0]     tx_turn_on,
  // Transmit link, one clock per channel
  input  wire logic [`QLT_NCH-1:0]     tx_line_clock,
  input  wire logic [`QLT_NCH-1:0]     tx_positive_rail_in,
  input  wire logic [`QLT_NCH-1:0]     tx_negative_rail_in,
  // Line drivers
  output logic [`QLT_NCH-1:0]          line_driver_out_a,
  output logic [`QLT_NCH-1:0]          line_driver_out_b,
  output logic [`QLT_NCH-1:0]          line_driver_oe,
  // Receiver power
  output logic [`QLT_NCH-1:0]          rx_power_on
);

  // ============================================================
  // Decoding helpers

  // One-hot channel control register hit for a word index
  function automatic logic [`QLT_NCH-1:0] ch_hit(
    input logic [7:0] idx
  );
    logic [`QLT_NCH-1:0] hit;
    hit    = '0;
    hit[0] = (idx == `QLT_IDX_CH0_CTRL);
    hit[1] = (idx == `QLT_IDX_CH1_CTRL);
    hit[2] = (idx == `QLT_IDX_CH2_CTRL);
    hit[3] = (idx == `QLT_IDX_CH3_CTRL);
    return hit;
  endfunction : ch_hit

  // ============================================================
  // State
  qlt_pkg::qlt_top_s      q, d;
  logic [`QLT_NCH-1:0]    txen_link;
  logic                   accept;
  logic [7:0]             addr_idx;

  assign addr_idx = haddr[`QLT_IDX_MSB:`QLT_IDX_LSB];
  assign accept   = hsel & hready & htrans[`QLT_HTRANS_ACT_BIT];

  // ============================================================
  // Next-state logic
  always_comb begin
    logic [`QLT_NCH-1:0] wr_hit;
    logic [`QLT_NCH-1:0] rd_hit;
    logic [31:0]         rd_word;
    wr_hit  = '0;
    rd_hit  = '0;
    rd_word = `QLT_RDATA_ZERO;
    d       = q;

    // Pins come from outside this clock: two flops each.
    // A floating mode pin is expected to settle high.
    d.mode_meta = control_mode_select;
    d.mode_hw   = q.mode_meta;
    // An open all-ones pin must read as low at the pad
    d.aos_meta  = tx_all_ones_command;
    d.aos_pin   = q.aos_meta;
    d.on_meta   = tx_turn_on;
    d.on_pin    = q.on_meta;
    d.txen_meta = txen_link;
    d.txen      = q.txen_meta;

    // Register writes land in the write data phase
    if (q.dp == qlt_pkg::QLT_DP_WRITE) begin
      wr_hit = ch_hit(q.dp_idx);
      for (int i = 0; i < `QLT_NCH; i++) begin
        if (wr_hit[i]) begin
          d.ch_ctrl[i] = hwdata[`QLT_REG_W-1:0];
        end
      end
      if (q.dp_idx == `QLT_IDX_GLOBAL) begin
        d.gl_ctrl = hwdata[`QLT_REG_W-1:0];
      end
    end

    // Reads take one wait cycle so hrdata comes from a flop
    if (q.dp == qlt_pkg::QLT_DP_RWAIT) begin
      rd_hit = ch_hit(q.dp_idx);
      for (int i = 0; i < `QLT_NCH; i++) begin
        if (rd_hit[i]) begin
          rd_word[`QLT_REG_W-1:0] = q.ch_ctrl[i];
        end
      end
      if (q.dp_idx == `QLT_IDX_GLOBAL) begin
        rd_word[`QLT_REG_W-1:0] = q.gl_ctrl;
      end
      if (q.dp_idx == `QLT_IDX_STATUS) begin
        rd_word[`QLT_ST_MODE_BIT] = q.mode_hw;
        rd_word[`QLT_ST_TXEN_LSB +: `QLT_NCH] = q.txen;
        rd_word[`QLT_ST_AOS_LSB +: `QLT_NCH] = q.aos_pin;
        rd_word[`QLT_ST_TURN_ON_LSB +: `QLT_NCH] = q.on_pin;
      end
      d.rdata = rd_word;
    end

    // Data-phase sequencing
    case (q.dp)
      qlt_pkg::QLT_DP_RWAIT: begin
        d.dp = qlt_pkg::QLT_DP_RDONE;
      end
      qlt_pkg::QLT_DP_IDLE,
      qlt_pkg::QLT_DP_WRITE,
      qlt_pkg::QLT_DP_RDONE: begin
        if (accept) begin
          d.dp     = hwrite ? qlt_pkg::QLT_DP_WRITE
                            : qlt_pkg::QLT_DP_RWAIT;
          d.dp_idx = addr_idx;
        end else begin
          d.dp     = qlt_pkg::QLT_DP_IDLE;
        end
      end
      default: begin
        d.dp = qlt_pkg::QLT_DP_IDLE;
      end
    endcase

    // Control selection per channel
    for (int i = 0; i < `QLT_NCH; i++) begin
      if (q.mode_hw) begin
        d.aos_ctl[i] = q.aos_pin[i];
        d.on_ctl[i]  = q.on_pin[i];
        d.rx_pwr[i]  = 1'h1;
      end else begin
        // Host mode: the all-ones pins serve the bus only
        d.aos_ctl[i] = q.ch_ctrl[i][`QLT_CH_ALL_ONES_BIT];
        d.on_ctl[i]  = q.gl_ctrl[`QLT_GL_PIN_SEL_BIT]
                       ? q.on_pin[i]
                       : q.ch_ctrl[i][`QLT_CH_TX_ON_BIT];
        d.rx_pwr[i]  = q.ch_ctrl[i][`QLT_CH_RX_PWR_BIT];
      end
    end
  end

  // ============================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q           <= '0;
      q.mode_meta <= 1'h1;
      q.mode_hw   <= 1'h1;
      q.ch_ctrl   <= {`QLT_NCH{`QLT_CH_CTRL_RST}};
      q.gl_ctrl   <= `QLT_GL_CTRL_RST;
      q.dp        <= qlt_pkg::QLT_DP_IDLE;
      q.rx_pwr    <= {`QLT_NCH{1'h1}};
    end else begin
      q <= d;
    end
  end

  // ============================================================
  // Bus outputs
  assign hreadyout   = (q.dp != qlt_pkg::QLT_DP_RWAIT);
  assign hrdata      = q.rdata;
  assign hresp       = `QLT_HRESP_OKAY;
  assign rx_power_on = q.rx_pwr;

  // ============================================================
  // Transmit channels, each on its own line clock
  generate
    for (genvar g = 0; g < `QLT_NCH; g++) begin : g_ch
      qlt_tx_channel u_ch (
        .tx_line_clock       (tx_line_clock[g]),
        .hresetn             (hresetn),
        .aos_ctl             (q.aos_ctl[g]),
        .on_ctl              (q.on_ctl[g]),
        .tx_positive_rail_in (tx_positive_rail_in[g]),
        .tx_negative_rail_in (tx_negative_rail_in[g]),
        .line_driver_out_a   (line_driver_out_a[g]),
        .line_driver_out_b   (line_driver_out_b[g]),
        .line_driver_oe      (line_driver_oe[g])
      );
      assign txen_link[g] = line_driver_oe[g];
    end
  endgenerate

endmodule : qlt_top

/* verification/qlt_top_props.sv */
`timescale 1ns/1ps

// ============================================================
// Port-level checks of the transmit control block
module qlt_top_props (
  // Bus
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hreadyout,
  // Pins and line
  input wire logic       control_mode_select,
  input wire logic [3:0] tx_all_ones_command,
  input wire logic [3:0] tx_turn_on,
  input wire logic [3:0] tx_line_clock,
  input wire logic [3:0] tx_positive_rail_in,
  input wire logic [3:0] tx_negative_rail_in,
  input wire logic [3:0] line_driver_out_a,
  input wire logic [3:0] line_driver_out_b,
  input wire logic [3:0] line_driver_oe,
  input wire logic [3:0] rx_power_on
);
  // ============================================================
  // Register access handshake
  sequence s_req;
    hsel && hreadyout && htrans[1];
  endsequence
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  AST_RD_WAIT: assert property (@(posedge hclk)
    disable iff (!hresetn) s_req ##0 !hwrite |=> s_rd_wait)
    else $error("read wait state wrong");
  AST_WR_NOWAIT: assert property (@(posedge hclk)
    disable iff (!hresetn) s_req ##0 hwrite |=> hreadyout)
    else $error("write stalled");
  // ============================================================
  // Pin controls
  AST_RX_HW: assert property (@(posedge hclk)
    disable iff (!hresetn) control_mode_select [*8] |-> rx_power_on == 4'hF)
    else $error("receiver off in hardware mode");
  AST_OFF_QUIET: assert property (@(posedge hclk)
    disable iff (!hresetn)
    ((line_driver_out_a | line_driver_out_b) & ~line_driver_oe) == 4'h0)
    else $error("disabled driver shows data");
  // Line checks watch channel 0 only, to keep the cost down
  AST_TX_OFF: assert property (@(posedge tx_line_clock[0])
    disable iff (!hresetn)
    (control_mode_select && !tx_turn_on[0]) [*6] |-> !line_driver_oe[0])
    else $error("driver on with turn-on low");
  AST_TX_ON: assert property (@(posedge tx_line_clock[0])
    disable iff (!hresetn)
    (control_mode_select && tx_turn_on[0]) [*6] |-> line_driver_oe[0])
    else $error("driver off with turn-on high");
  AST_DATA_A: assert property (@(posedge tx_line_clock[0])
    disable iff (!hresetn)
    (control_mode_select && !tx_all_ones_command[0]
     && line_driver_oe[0]) [*6]
    |-> line_driver_out_a[0] == $past(tx_positive_rail_in[0], 2))
    else $error("positive rail not passed");
  AST_DATA_B: assert property (@(posedge tx_line_clock[0])
    disable iff (!hresetn)
    (control_mode_select && !tx_all_ones_command[0]
     && line_driver_oe[0]) [*6]
    |-> line_driver_out_b[0] == $past(tx_negative_rail_in[0], 2))
    else $error("negative rail not passed");
  AST_ONES: assert property (@(posedge tx_line_clock[0])
    disable iff (!hresetn)
    (control_mode_select && tx_all_ones_command[0]
     && line_driver_oe[0]) [*7]
    |-> line_driver_out_a[0] != line_driver_out_b[0]
        && line_driver_out_a[0] != $past(line_driver_out_a[0]))
    else $error("all-ones pattern wrong");
endmodule : qlt_top_props

bind qlt_top qlt_top_props u_props (.*);

/* verification/qlt_framer_model.sv */
`timescale 1ns/1ps

// ============================================================
// Framer model: free-running line clocks and a dual-rail stream
module qlt_framer_model (
  // Link
  output logic [3:0] tx_line_clock,
  output logic [3:0] tx_positive_rail_in,
  output logic [3:0] tx_negative_rail_in
);
  for (genvar g = 0; g < 4; g++) begin : gch
    logic       clk = 1'h0;
    logic [4:0] s   = 5'h0;
    logic       p   = 1'h0;
    logic       n   = 1'h0;
    // Half-ns offsets keep line edges clear of host-clock sampling
    initial begin
      #(8.5 + 4 * g + g % 2) clk = 1'h1;
      forever #40 clk = ~clk;
    end
    // Rails change just after the edge and are never both high
    always @(posedge clk) begin
      s <= s + 5'h3 + 5'(g);
      p <= s[0] ^ s[3];
      n <= ~(s[0] ^ s[3]) & s[1];
    end
    assign tx_line_clock[g]       = clk;
    assign tx_positive_rail_in[g] = p;
    assign tx_negative_rail_in[g] = n;
  end
endmodule : qlt_framer_model

/* verification/qlt_top_bench.sv */
`timescale 1ns/1ps
`define CHK(a, e, m) begin checks_done++; \
  if ((a) !== (e)) begin num_errors++; \
  $display("ERROR %0t %s", $time, m); end end

module qlt_top_bench;
  logic         hclk;
  logic         hresetn;
  logic         hsel;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [2:0]   hsize;
  logic [31:0]  hwdata;
  logic         hready;
  logic         hreadyout;
  logic [31:0]  hrdata;
  logic         hresp;
  logic         control_mode_select;
  logic [3:0]   tx_all_ones_command;
  logic [3:0]   tx_turn_on;
  logic [3:0]   tx_line_clock;
  logic [3:0]   tx_positive_rail_in;
  logic [3:0]   tx_negative_rail_in;
  logic [3:0]   line_driver_out_a;
  logic [3:0]   line_driver_out_b;
  logic [3:0]   line_driver_oe;
  logic [3:0]   rx_power_on;
  logic [31:0]  rd;
  logic [163:0] ph;
  logic [163:0] nh;
  int           num_errors = 0;
  int           checks_done = 0;
  int           cyc = 0;
  localparam logic [31:0] CTAB = 32'h0001_0503;

  assign hready = hreadyout;
  qlt_top uut (.*);
  qlt_framer_model fm (.*);

  initial begin
    hclk = 1'h0;
    forever #2 hclk = ~hclk;
  end

  // Rail history at host rate: entry 40 is one line-path delay back
  always @(posedge hclk) begin
    ph <= {ph[159:0], tx_positive_rail_in};
    nh <= {nh[159:0], tx_negative_rail_in};
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end

  // ============================================================
  // Bus and line tasks
  task automatic ahb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {22'h0, idx, 2'h0};
    do @(posedge hclk); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask : ahb

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] e);
    ahb(1'h0, idx, 32'h0);
    `CHK(rd, e, "read value")
    `CHK(hresp, 1'h0, "response")
  endtask : rdchk

  task automatic chk_line(input logic [3:0] oe_e, input logic [3:0] on_e);
    logic [3:0] a1;
    repeat (400) @(posedge hclk);
    #1 a1 = line_driver_out_a;
    `CHK(line_driver_oe, oe_e, "driver enable")
    repeat (20) @(posedge hclk);
    #1;
    `CHK(line_driver_out_a, oe_e & (on_e & ~a1 | ~on_e & ph[163:160]), "a")
    `CHK(line_driver_out_b, oe_e & (on_e & a1 | ~on_e & nh[163:160]), "b")
  endtask : chk_line

  task test_done;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // ============================================================
  // Main sequence
  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    control_mode_select = 1'h1;
    tx_all_ones_command = 4'h0;
    tx_turn_on = 4'h0;
    // Each line clock sees a rising edge while reset is held
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      rdchk(i[7:0], 32'h0000_0004);
    end
    rdchk(8'h42, 32'h0);
    ahb(1'h1, 8'h10, 32'hFF);
    rdchk(8'h10, 32'h0);
    `CHK(rx_power_on, 4'hF, "receiver power")
    chk_line(4'h0, 4'h0);
    $display("reset test done");
    tx_turn_on <= 4'hB;
    tx_all_ones_command <= 4'h5;
    chk_line(4'hB, 4'h5);
    $display("hardware test done");
    control_mode_select <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      ahb(1'h1, i[7:0], {24'h0, CTAB[8*i+:8]});
    end
    for (int i = 0; i < 4; i++) begin
      rdchk(i[7:0], {24'h0, CTAB[8*i+:8]});
    end
    chk_line(4'h7, 4'h1);
    `CHK(rx_power_on, 4'h2, "receiver power")
    $display("host test done");
    ahb(1'h1, 8'h42, 32'h40);
    rdchk(8'h42, 32'h40);
    chk_line(4'hB, 4'h1);
    rdchk(8'h40, 32'h0000_B5B0);
    $display("pin select test done");
    control_mode_select <= 1'h1;
    tx_turn_on <= 4'h7;
    tx_all_ones_command <= 4'hA;
    chk_line(4'h7, 4'hA);
    `CHK(rx_power_on, 4'hF, "receiver power")
    rdchk(8'h40, 32'h0000_7A71);
    $display("return test done");
    test_done();
  end
endmodule : qlt_top_bench
